/* verilog/modem_ctl_pkg.sv */
// ==========================================================================
// shared constants and types
package modem_ctl_pkg;

  // ========================================================================
  // register addresses on the serial control bus
  localparam logic [7:0] ADDR_OUT_GAIN = 8'hB0;
  localparam logic [7:0] ADDR_IN_ROUTE = 8'hB1;
  localparam logic [7:0] ADDR_TX_WORD0 = 8'hB5;
  localparam logic [7:0] ADDR_RX_WORD0 = 8'hB6;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hC1;
  localparam logic [7:0] ADDR_VOC_GAIN = 8'hC3;
  localparam logic [7:0] ADDR_STATUS = 8'hC6;
  localparam logic [7:0] ADDR_MODEM_CFG = 8'hC7;
  localparam logic [7:0] ADDR_PROGRAM = 8'hC8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hCE;

  // ========================================================================
  // field positions
  localparam int INVERT_BIT = 7;
  localparam int CODEC_EN_BIT = 0;
  localparam int IN1_SRC_LSB = 2;
  localparam int IN2_SRC_LSB = 4;
  localparam int CFG_MOD_IQ_BIT = 0;
  localparam int CFG_VOC_DIS_BIT = 5;
  localparam int DEMOD_FLIP_BIT = 1;
  localparam int HOST_ADDR_BITS = 8;
  localparam int HOST_WORD_BITS = 24;
  localparam logic [15:0] PROG_PTR_DEMOD = 16'h000A;

  // ========================================================================
  // mode field codes, control sub-field codes and reset values
  localparam logic [3:0] CODE_IDLE = 4'h0;
  localparam logic [3:0] CODE_RX = 4'h1;
  localparam logic [3:0] CODE_TX = 4'h2;
  localparam logic [3:0] CODE_PASS = 4'h4;
  localparam logic [3:0] CODE_RX_CAL = 4'h5;
  localparam logic [3:0] CODE_RX_PSAVE = 4'h9;
  localparam logic [3:0] CTRL_IDLE = 4'h0;
  localparam logic [3:0] CTRL_FORMATTED = 4'h1;
  localparam logic [3:0] CTRL_RX_RAW = 4'h2;
  localparam logic [3:0] CTRL_TX_SETUP = 4'h5;
  localparam logic [3:0] CTRL_ABORT = 4'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_IDLE = 6'b000001,
    MODE_RX = 6'b000010,
    MODE_TX = 6'b000100,
    MODE_PASS = 6'b001000,
    MODE_RX_CAL = 6'b010000,
    MODE_RX_PSAVE = 6'b100000
  } mode_t;

  // one word moved to the external vocoder in pass-through
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } voc_xfer_t;

endpackage : modem_ctl_pkg

/* verilog/modem_mode_routing_control.sv */
// Functional notes
// RQ1: low four mode bits select idle, rx, tx, pass-through, rx cal, rx powersave.
// RQ2: receive enable pin follows bit 0, transmit enable bit 1, both active low.
// RQ3: reset leaves the block in idle mode with no host action.
// RQ4: auxiliary converter inputs keep sampling in idle whenever enabled.
// RQ5: programming register writes are taken only in idle mode.
// RQ6: pass-through is refused while in a receive or transmit mode.
// RQ7: pass-through moves word zero to or from the addressed vocoder register.
// RQ8: control sub-field is ignored while pass-through is selected.
// RQ9: bits 7 to 4 select the modem action; reserved codes are refused.
// RQ10: host writes mode and control sub-field in one bus write.
// RQ11: routing field bits 5 to 2 can swap the i and q inputs.
// RQ12: output gain bit 7 inverts the analogue receive inputs.
// RQ13: block 0 word 10 bit 1 inverts the demodulated symbols.
// RQ14: second input path is used only in external codec mode.
// RQ15: host routes input 1 to limiter detector, input 2 to secondary.
// RQ16: outputs carry two-point or i/q signals per modulation type.
// RQ17: formatted modes route audio via vocoder for speech unless disabled.
// RQ18: vocoder gain register contents are forwarded to the vocoder.
// RQ19: host should watch the interrupt pin rather than poll status; this block has no interrupt pin and never decodes ADDR_IRQ_MASK.
// RQ20: input 1 may take secondary, limiter detector or voice pickup.
// RQ21: rx or tx speeds the clock and wakes vocoder; idle slows it.
// RQ22: reserved mode or control codes leave mode and pins unchanged.
`timescale 1ns/10ps
module modem_mode_routing_control import modem_ctl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial control bus pins
  input wire logic host_csn_n,
  input wire logic host_sclk,
  input wire logic host_din,
  output logic host_dout,
  output logic host_dout_oe,
  // external vocoder transfer
  output voc_xfer_t voc_xfer,
  output logic voc_xfer_stb,
  input wire logic [15:0] voc_rdata,
  input wire logic voc_rvalid,
  output logic [15:0] voc_gain,
  output logic voc_gain_stb,
  // loose inputs from the modem core
  input wire logic aux_adc_enable,
  input wire logic sacch_speech,
  // pins and routing controls
  output logic receive_enable_pin_n,
  output logic transmit_enable_pin_n,
  output mode_t current_mode,
  output logic [3:0] modem_action,
  output logic fast_clock_req,
  output logic vocoder_wake,
  output logic aux_sample_en,
  output logic input_invert,
  output logic [1:0] in1_source,
  output logic [1:0] in2_source,
  output logic in2_path_en,
  output logic demod_polarity_flip,
  output logic mod_iq_select,
  output logic vocoder_route
);

  // ========================================================================
  // decode helpers
  function automatic logic rx_family(input mode_t m);
    rx_family = (m == MODE_RX) || (m == MODE_RX_CAL) || (m == MODE_RX_PSAVE);
  endfunction : rx_family

  function automatic logic mode_known(input logic [3:0] c);
    mode_known = (c == CODE_IDLE) || (c == CODE_RX) || (c == CODE_TX) ||
                 (c == CODE_PASS) || (c == CODE_RX_CAL) || (c == CODE_RX_PSAVE);
  endfunction : mode_known

  // ========================================================================
  // pin synchronisers: only stage two and the edge register are read
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic sclk_prev_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h1;
      sync2_q <= 3'h1;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {host_din, host_sclk, host_csn_n};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[1];
    end
  end

  wire frame = ~sync2_q[0];
  wire sclk_rise = frame & sync2_q[1] & ~sclk_prev_q;
  wire sclk_fall = frame & ~sync2_q[1] & sclk_prev_q;

  // ========================================================================
  // serial shifter: one address byte then sixteen data bits, msb first
  logic [4:0] bit_cnt_q;
  logic [22:0] shift_q;
  logic [15:0] rd_shift_q;
  logic dout_oe_q;
  wire [23:0] word_w = {shift_q, sync2_q[2]};
  wire [7:0] wr_addr = word_w[23:16];
  wire [15:0] wr_data = word_w[15:0];
  wire addr_done = sclk_rise && (bit_cnt_q == 5'(HOST_ADDR_BITS - 1));
  wire wr_fire = sclk_rise && (bit_cnt_q == 5'(HOST_WORD_BITS - 1)) && !dout_oe_q;

  // counter saturates so extra clocks in a frame do nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 23'h000000;
    end else if (!frame) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      shift_q <= word_w[22:0];
      if (bit_cnt_q != 5'(HOST_WORD_BITS)) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // ========================================================================
  // mode field write decode
  mode_t mode_q;
  logic [3:0] ctrl_q;
  wire is_mode_wr = wr_fire && (wr_addr == ADDR_MODE_CTRL);
  wire [3:0] new_code = wr_data[3:0];
  wire [3:0] new_ctrl = wr_data[7:4];
  wire active = rx_family(mode_q) || (mode_q == MODE_TX);
  mode_t new_mode;
  always_comb begin
    unique case (new_code) // RQ1
      CODE_RX: new_mode = MODE_RX;
      CODE_TX: new_mode = MODE_TX;
      CODE_PASS: new_mode = MODE_PASS;
      CODE_RX_CAL: new_mode = MODE_RX_CAL;
      CODE_RX_PSAVE: new_mode = MODE_RX_PSAVE;
      default: new_mode = MODE_IDLE;
    endcase
  end

  // reserved actions differ between receive and transmit
  wire ctrl_ok = (new_mode == MODE_PASS) || // RQ8
                 ((new_ctrl <= CTRL_ABORT) && // RQ9
                  !(rx_family(new_mode) && new_ctrl == CTRL_TX_SETUP) &&
                  !(new_mode == MODE_TX && new_ctrl == CTRL_RX_RAW));
  wire pass_refused = (new_mode == MODE_PASS) && active; // RQ6
  wire mode_take = is_mode_wr && mode_known(new_code) && ctrl_ok && !pass_refused; // RQ22

  // mode, action and enable pins move together on one accepted write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_IDLE; // RQ3
      ctrl_q <= CTRL_IDLE;
      receive_enable_pin_n <= 1'b1;
      transmit_enable_pin_n <= 1'b1;
    end else if (mode_take) begin
      mode_q <= new_mode;
      ctrl_q <= (new_mode == MODE_PASS) ? CTRL_IDLE : new_ctrl; // RQ8
      receive_enable_pin_n <= ~new_code[0]; // RQ2
      transmit_enable_pin_n <= ~new_code[1]; // RQ2
    end
  end

  // ========================================================================
  // routing and gain registers
  logic [15:0] cfg_q;
  logic voc_dis;
  wire [1:0] in1_w = wr_data[IN1_SRC_LSB +: 2];
  wire [1:0] in2_w = wr_data[IN2_SRC_LSB +: 2];
  assign voc_dis = cfg_q[CFG_VOC_DIS_BIT];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_invert <= 1'b0;
      in1_source <= 2'h0;
      in2_source <= 2'h0;
      in2_path_en <= 1'b0;
      cfg_q <= REG_RESET;
    end else if (wr_fire) begin
      if (wr_addr == ADDR_OUT_GAIN) begin
        input_invert <= wr_data[INVERT_BIT]; // RQ12
      end
      if (wr_addr == ADDR_IN_ROUTE) begin
        in1_source <= in1_w; // RQ20 RQ11
        in2_source <= in2_w; // RQ11
        in2_path_en <= wr_data[CODEC_EN_BIT]; // RQ14
      end
      if (wr_addr == ADDR_MODEM_CFG) begin
        cfg_q <= wr_data;
      end
    end
  end

  // ========================================================================
  // programming register: pointer word, then data word, idle only
  logic [15:0] prog_ptr_q;
  logic prog_phase_q;
  wire prog_take = wr_fire && (wr_addr == ADDR_PROGRAM) && (mode_q == MODE_IDLE); // RQ5
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_ptr_q <= REG_RESET;
      prog_phase_q <= 1'b0;
      demod_polarity_flip <= 1'b0;
    end else if (prog_take) begin
      prog_phase_q <= ~prog_phase_q;
      if (!prog_phase_q) begin
        prog_ptr_q <= wr_data;
      end else if (prog_ptr_q == PROG_PTR_DEMOD) begin
        demod_polarity_flip <= wr_data[DEMOD_FLIP_BIT]; // RQ13
      end
    end
  end

  // ========================================================================
  // vocoder traffic: pass-through words and gain forwarding
  logic [15:0] rx_word0_q;
  wire pass_tx = wr_fire && (wr_addr == ADDR_TX_WORD0) && (mode_q == MODE_PASS);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      voc_xfer <= '0;
      voc_xfer_stb <= 1'b0;
      rx_word0_q <= REG_RESET;
      voc_gain <= REG_RESET;
      voc_gain_stb <= 1'b0;
    end else begin
      voc_xfer_stb <= pass_tx; // RQ7
      voc_gain_stb <= wr_fire && (wr_addr == ADDR_VOC_GAIN); // RQ18
      if (pass_tx) begin
        voc_xfer <= '{addr: prog_ptr_q[7:0], data: wr_data}; // RQ7
      end
      if (voc_rvalid && mode_q == MODE_PASS) begin
        rx_word0_q <= voc_rdata; // RQ7
      end
      if (wr_fire && wr_addr == ADDR_VOC_GAIN) begin
        voc_gain <= wr_data; // RQ18
      end
    end
  end

  // ========================================================================
  // derived controls, registered so every output leaves a flip-flop
  wire formatted = (rx_family(mode_q) || mode_q == MODE_TX) && (ctrl_q == CTRL_FORMATTED);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fast_clock_req <= 1'b0;
      vocoder_wake <= 1'b0;
      aux_sample_en <= 1'b0;
      mod_iq_select <= 1'b0;
      vocoder_route <= 1'b0;
    end else begin
      fast_clock_req <= active; // RQ21
      vocoder_wake <= active; // RQ21
      aux_sample_en <= aux_adc_enable; // RQ4
      mod_iq_select <= cfg_q[CFG_MOD_IQ_BIT]; // RQ16
      vocoder_route <= formatted && sacch_speech && !voc_dis; // RQ17
    end
  end
  assign current_mode = mode_q;
  assign modem_action = ctrl_q;

  // ========================================================================
  // read path: status and received word zero; others stay undriven
  wire is_rd_addr = (word_w[7:0] == ADDR_STATUS) || (word_w[7:0] == ADDR_RX_WORD0);
  wire [15:0] status_w = {4'h0, ctrl_q, mode_q, 1'b0, (mode_q == MODE_IDLE)};
  wire [15:0] rd_val = (word_w[7:0] == ADDR_STATUS) ? status_w : rx_word0_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_shift_q <= REG_RESET;
      dout_oe_q <= 1'b0;
    end else if (!frame) begin
      dout_oe_q <= 1'b0;
    end else if (addr_done && is_rd_addr) begin
      rd_shift_q <= rd_val;
      dout_oe_q <= 1'b1;
    end else if (sclk_fall && dout_oe_q && bit_cnt_q != 5'(HOST_ADDR_BITS)) begin
      rd_shift_q <= {rd_shift_q[14:0], 1'b0};
    end
  end
  assign host_dout = rd_shift_q[15];
  assign host_dout_oe = dout_oe_q;

  // ========================================================================
  // checks
  property p_reset_idle;
    @(posedge clk) disable iff (!rstn)
      !$past(rstn) |-> mode_q == MODE_IDLE && receive_enable_pin_n && transmit_enable_pin_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // RQ3

  property p_pins;
    @(posedge clk) disable iff (!rstn)
      receive_enable_pin_n == !rx_family(mode_q) &&
      transmit_enable_pin_n == !(mode_q == MODE_TX);
  endproperty
  a_pins: assert property (p_pins) else $error("enable pins disagree with mode"); // RQ2

  property p_rx_decode;
    @(posedge clk) disable iff (!rstn)
      is_mode_wr && new_code == CODE_RX && new_ctrl == CTRL_FORMATTED |=> mode_q == MODE_RX;
  endproperty
  a_rx_decode: assert property (p_rx_decode) else $error("rx code not decoded"); // RQ1

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
      is_mode_wr && (!mode_known(new_code) || !ctrl_ok) |=> $stable(mode_q) && $stable(ctrl_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code changed mode"); // RQ22

  property p_pass_refused;
    @(posedge clk) disable iff (!rstn)
      is_mode_wr && new_code == CODE_PASS && active |=> mode_q != MODE_PASS;
  endproperty
  a_pass_refused: assert property (p_pass_refused) else $error("pass entered from rx/tx"); // RQ6

  property p_prog_idle;
    @(posedge clk) disable iff (!rstn)
      $changed(prog_ptr_q) || $changed(demod_polarity_flip) |-> $past(mode_q) == MODE_IDLE;
  endproperty
  a_prog_idle: assert property (p_prog_idle) else $error("program write outside idle"); // RQ5

  property p_pass_ctrl;
    @(posedge clk) disable iff (!rstn)
      mode_q == MODE_PASS |-> ctrl_q == CTRL_IDLE;
  endproperty
  a_pass_ctrl: assert property (p_pass_ctrl) else $error("action kept in pass"); // RQ8

  property p_pass_xfer;
    @(posedge clk) disable iff (!rstn)
      voc_xfer_stb |-> $past(mode_q) == MODE_PASS && voc_xfer.addr == prog_ptr_q[7:0];
  endproperty
  a_pass_xfer: assert property (p_pass_xfer) else $error("bad pass-through transfer"); // RQ7

  property p_clock_speed;
    @(posedge clk) disable iff (!rstn)
      ##1 fast_clock_req == $past(active) && vocoder_wake == fast_clock_req;
  endproperty
  a_clock_speed: assert property (p_clock_speed) else $error("clock request wrong"); // RQ21

  property p_route;
    @(posedge clk) disable iff (!rstn)
      vocoder_route |-> $past(formatted) && $past(sacch_speech) && !$past(voc_dis);
  endproperty
  a_route: assert property (p_route) else $error("vocoder routed wrongly"); // RQ17

endmodule : modem_mode_routing_control

/* verif/host_bus_model.sv */
`timescale 1ns/10ps
// ====
// host side of the serial control bus: whole 24-bit frames only
module host_bus_model (
  // clock
  input wire logic clk,
  // serial bus pins
  output logic csn_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  // six cycles a phase keeps clear of the two-stage synchroniser
  localparam int HALF = 6;

  initial begin
    csn_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // address and data go out in one frame, msb first, read bits taken before each rise
  task automatic shift_frame(input logic [7:0] a, input logic [15:0] d,
                             output logic [15:0] q, output logic oe);
    logic [23:0] w;
    w = {a, d};
    q = 16'h0000;
    oe = 1'b0;
    @(negedge clk);
    csn_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      din <= w[i];
      repeat (HALF) @(negedge clk);
      if (i < 16) q = {q[14:0], dout};
      oe = oe | dout_oe;
      sclk <= 1'b1;
      repeat (HALF) @(negedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(negedge clk);
    csn_n <= 1'b1;
    // released data line shows the inverse so a stale bit is never trusted
    din <= ~din;
    repeat (HALF) @(negedge clk);
  endtask : shift_frame
endmodule : host_bus_model

/* verif/modem_mode_routing_control_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, (exp), (got)); \
  end \
end
module modem_mode_routing_control_bench import modem_ctl_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic csn_n, sclk, din, dout, dout_oe, oe_seen;
  voc_xfer_t voc_xfer, last_xfer;
  logic voc_xfer_stb, voc_gain_stb, voc_rvalid = 1'b0, aux = 1'b0, speech = 1'b0;
  logic [15:0] voc_rdata = 16'h0000, voc_gain, rd;
  logic rx_n, tx_n, fast_clk, wake, aux_en, inv, in2_en, flip, iq, route;
  mode_t cur_mode;
  logic [3:0] action;
  logic [1:0] in1, in2;
  int n_errors = 0, samples_checked = 0, n_xfer = 0, n_gain = 0, cycles = 0;

  always #12.5 clk = ~clk;

  modem_mode_routing_control i_dut (.clk(clk), .rstn(rstn), .host_csn_n(csn_n),
    .host_sclk(sclk), .host_din(din), .host_dout(dout), .host_dout_oe(dout_oe),
    .voc_xfer(voc_xfer), .voc_xfer_stb(voc_xfer_stb), .voc_rdata(voc_rdata),
    .voc_rvalid(voc_rvalid), .voc_gain(voc_gain), .voc_gain_stb(voc_gain_stb),
    .aux_adc_enable(aux), .sacch_speech(speech), .receive_enable_pin_n(rx_n),
    .transmit_enable_pin_n(tx_n), .current_mode(cur_mode), .modem_action(action),
    .fast_clock_req(fast_clk), .vocoder_wake(wake), .aux_sample_en(aux_en),
    .input_invert(inv), .in1_source(in1), .in2_source(in2), .in2_path_en(in2_en),
    .demod_polarity_flip(flip), .mod_iq_select(iq), .vocoder_route(route));

  host_bus_model i_host (.clk(clk), .csn_n(csn_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe));

  // ====
  // strobe counters; a pulse wider than one cycle shows up as an extra count
  always @(posedge clk) begin
    cycles++;
    if (voc_xfer_stb === 1'b1) begin
      n_xfer++;
      last_xfer = voc_xfer;
    end
    if (voc_gain_stb === 1'b1) n_gain++;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_host.shift_frame(a, d, rd, oe_seen);
  endtask : wr

  task automatic chk_mode(input mode_t m, input logic rxn, input logic txn, input logic [3:0] c);
    `CHK("mode", m, cur_mode)
    `CHK("rx_pin", rxn, rx_n)
    `CHK("tx_pin", txn, tx_n)
    `CHK("action", c, action)
  endtask : chk_mode

  // ====
  // each rx and tx mode code in and back to idle, clock request following
  task automatic t_modes();
    logic [3:0] codes [4] = '{CODE_RX, CODE_TX, CODE_RX_CAL, CODE_RX_PSAVE};
    mode_t modes [4] = '{MODE_RX, MODE_TX, MODE_RX_CAL, MODE_RX_PSAVE};
    chk_mode(MODE_IDLE, 1'b1, 1'b1, 4'h0);
    `CHK("aux", 1'b0, aux_en)
    `CHK("fast_clk", 1'b0, fast_clk)
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE_CTRL, {8'h00, 4'h3, codes[i]});
      chk_mode(modes[i], codes[i] == CODE_TX, codes[i] != CODE_TX, 4'h3);
      `CHK("fast_clk", 1'b1, fast_clk)
      `CHK("wake", 1'b1, wake)
      wr(ADDR_MODE_CTRL, 16'h0070);
      chk_mode(MODE_IDLE, 1'b1, 1'b1, 4'h7);
      `CHK("fast_clk", 1'b0, fast_clk)
      `CHK("wake", 1'b0, wake)
    end
  endtask : t_modes

  // ====
  // reserved codes and forbidden pairings leave mode, action and pins alone
  task automatic t_refuse();
    logic [15:0] bad [5] = '{16'h0013, 16'h0006, 16'h000F, 16'h0081, 16'h0004};
    wr(ADDR_MODE_CTRL, 16'h0001);
    for (int a = 1; a < 8; a++) begin
      wr(ADDR_MODE_CTRL, {8'h00, a[3:0], CODE_RX});
      chk_mode(MODE_RX, 1'b0, 1'b1, (a == 5) ? 4'h4 : a[3:0]);
    end
    foreach (bad[i]) begin
      wr(ADDR_MODE_CTRL, bad[i]);
      chk_mode(MODE_RX, 1'b0, 1'b1, 4'h7);
    end
    wr(ADDR_MODE_CTRL, 16'h0012);
    wr(ADDR_MODE_CTRL, 16'h0022);
    wr(ADDR_MODE_CTRL, 16'h0004);
    chk_mode(MODE_TX, 1'b1, 1'b0, 4'h1);
  endtask : t_refuse

  // ====
  // programming only in idle, then a pass-through word each way
  task automatic t_prog_pass();
    wr(ADDR_MODE_CTRL, 16'h0000);
    // a single status read after the return to idle, never a polling loop
    i_host.shift_frame(ADDR_STATUS, 16'h0000, rd, oe_seen);
    `CHK("status", 16'h0005, rd)
    wr(ADDR_PROGRAM, PROG_PTR_DEMOD);
    wr(ADDR_PROGRAM, 16'h0002);
    `CHK("flip", 1'b1, flip)
    wr(ADDR_MODE_CTRL, 16'h0001);
    wr(ADDR_PROGRAM, PROG_PTR_DEMOD);
    wr(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_PROGRAM, PROG_PTR_DEMOD);
    wr(ADDR_PROGRAM, 16'h0000);
    `CHK("flip", 1'b0, flip)
    wr(ADDR_PROGRAM, 16'h0033);
    wr(ADDR_PROGRAM, 16'h0000);
    wr(ADDR_MODE_CTRL, 16'h0074);
    chk_mode(MODE_PASS, 1'b1, 1'b1, 4'h0);
    n_xfer = 0;
    wr(ADDR_TX_WORD0, 16'hBEEF);
    `CHK("xfer_count", 1, n_xfer)
    `CHK("xfer", {8'h33, 16'hBEEF}, last_xfer)
    @(negedge clk) voc_rdata = 16'h1234;
    voc_rvalid = 1'b1;
    @(negedge clk) voc_rvalid = 1'b0;
    voc_rdata = 16'hEDCB;
    i_host.shift_frame(ADDR_RX_WORD0, 16'h0000, rd, oe_seen);
    `CHK("rx_word0", 16'h1234, rd)
    `CHK("read_oe", 1'b1, oe_seen)
    wr(ADDR_MODE_CTRL, 16'h0000);
  endtask : t_prog_pass

  // ====
  // input routing, inversion, modulation type, vocoder path and gain
  task automatic t_route();
    wr(ADDR_OUT_GAIN, 16'h0080);
    wr(ADDR_IN_ROUTE, 16'h003D);
    `CHK("invert", 1'b1, inv)
    `CHK("in1", 2'b11, in1)
    `CHK("in2", 2'b11, in2)
    `CHK("in2_en", 1'b1, in2_en)
    wr(ADDR_OUT_GAIN, 16'h007F);
    wr(ADDR_IN_ROUTE, 16'h0018);
    `CHK("invert", 1'b0, inv)
    `CHK("in1", 2'b10, in1)
    `CHK("in2", 2'b01, in2)
    `CHK("in2_en", 1'b0, in2_en)
    wr(8'hD0, 16'hFFFF);
    `CHK("invert", 1'b0, inv)
    i_host.shift_frame(8'hD0, 16'h0000, rd, oe_seen);
    `CHK("unmapped_oe", 1'b0, oe_seen)
    wr(ADDR_MODEM_CFG, 16'h0001);
    `CHK("iq", 1'b1, iq)
    @(negedge clk) speech = 1'b1;
    wr(ADDR_MODE_CTRL, 16'h0011);
    `CHK("route", 1'b1, route)
    i_host.shift_frame(ADDR_STATUS, 16'h0000, rd, oe_seen);
    `CHK("status", 16'h0108, rd)
    wr(ADDR_MODEM_CFG, 16'h0020);
    `CHK("route", 1'b0, route)
    `CHK("iq", 1'b0, iq)
    wr(ADDR_VOC_GAIN, 16'h5A3C);
    `CHK("gain", 16'h5A3C, voc_gain)
    `CHK("gain_count", 1, n_gain)
    wr(ADDR_MODE_CTRL, 16'h0000);
    @(negedge clk) aux = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("aux", 1'b1, aux_en)
  endtask : t_route

  // ====
  // reset in mid-run: idle again, input inversion cleared, programming pairing restarts
  task automatic t_reset();
    wr(ADDR_PROGRAM, PROG_PTR_DEMOD);
    wr(ADDR_OUT_GAIN, 16'h0080);
    wr(ADDR_MODE_CTRL, 16'h0012);
    @(negedge clk) rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk_mode(MODE_IDLE, 1'b1, 1'b1, 4'h0);
    `CHK("fast_clk", 1'b0, fast_clk)
    `CHK("invert", 1'b0, inv)
    wr(ADDR_PROGRAM, PROG_PTR_DEMOD);
    wr(ADDR_PROGRAM, 16'h0002);
    `CHK("flip", 1'b1, flip)
  endtask : t_reset

  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_modes();
    t_refuse();
    t_prog_pass();
    t_route();
    t_reset();
    complete_run();
  end
endmodule : modem_mode_routing_control_bench
